/* inc/dtq_consts.svh */
`ifndef DTQ_CONSTS_SVH
`define DTQ_CONSTS_SVH

// Clock and qualification time base
`define DTQ_CLK_NS        10
`define DTQ_TICK_US       100
`define DTQ_TICK_NS       100000
`define DTQ_TICK_CYC      (`DTQ_TICK_NS / `DTQ_CLK_NS)

// Durations in microseconds, normal and fast detection
`define DTQ_DROP1_US      400
`define DTQ_DROP2_NORM_US 10000
`define DTQ_DROP2_FAST_US 3000
`define DTQ_DELAY_NORM_US 41000
`define DTQ_DELAY_FAST_US 26000
`define DTQ_HOLD_NORM_US  28000
`define DTQ_HOLD_FAST_US  20000
`define DTQ_SPDLY_US      600

// Output values at rest
`define DTQ_CODE_IDLE     4'h0
`define DTQ_STROBE_IDLE   1'b1

`endif

/* inc/dtq_pkg.sv */
package dtq_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_QUAL  = 2'b01,
      ST_CODE  = 2'b10,
      ST_VALID = 2'b11
   } dtq_state_type;

   typedef struct packed {
      dtq_state_type state;
      logic [15:0]   tick_cnt;
      logic          tick;
      logic [11:0]   on_cnt;
      logic [11:0]   gap_cnt;
      logic [3:0]    cand;
      logic [3:0]    code;
      logic          strobe_n;
   } dtq_regs_type;

endpackage : dtq_pkg

/* src/dtq_qualifier.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtq_consts.svh"

module dtq_qualifier
   import dtq_pkg::*;
#(
   parameter int TICK_CYC = `DTQ_TICK_CYC
) (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // Tone detector
   input  wire logic       i_tone_present,
   input  wire logic [3:0] i_tone_code,
   // Control
   input  wire logic       i_fast_detect_select,
   input  wire logic       i_power_down,
   // Host outputs
   output logic      [3:0] o_received_digit_code,
   output logic            o_digit_valid_strobe_n
);

   function automatic logic [11:0] to_ticks(input int us);
      return 12'((us + `DTQ_TICK_US - 1) / `DTQ_TICK_US);
   endfunction : to_ticks

   function automatic logic [11:0] sel_ticks(input logic fast,
                                             input int   norm_us,
                                             input int   fast_us);
      return fast ? to_ticks(fast_us) : to_ticks(norm_us);
   endfunction : sel_ticks

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

   dtq_regs_type q;
   dtq_regs_type d;
   logic [11:0]  delay_ticks;
   logic [11:0]  hold_ticks;
   logic [11:0]  drop1_ticks;
   logic [11:0]  drop2_ticks;
   logic [11:0]  spdly_ticks;

   always_comb begin
      delay_ticks = sel_ticks(i_fast_detect_select, `DTQ_DELAY_NORM_US,
                              `DTQ_DELAY_FAST_US);
      hold_ticks  = sel_ticks(i_fast_detect_select, `DTQ_HOLD_NORM_US,
                              `DTQ_HOLD_FAST_US);
      drop2_ticks = sel_ticks(i_fast_detect_select, `DTQ_DROP2_NORM_US,
                              `DTQ_DROP2_FAST_US);
      drop1_ticks = to_ticks(`DTQ_DROP1_US);
      spdly_ticks = to_ticks(`DTQ_SPDLY_US);
   end

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      // Time base divider
      if (q.tick_cnt >= TICK_LAST) begin
         d.tick_cnt = 16'h0000;
         d.tick     = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 16'h0001;
      end
      case (q.state)
         ST_IDLE: begin
            d.code     = `DTQ_CODE_IDLE;
            d.strobe_n = `DTQ_STROBE_IDLE;
            d.on_cnt   = 12'h000;
            d.gap_cnt  = 12'h000;
            if (i_tone_present) begin
               d.state = ST_QUAL;
               d.cand  = i_tone_code;
            end
         end
         ST_QUAL: begin
            // Outputs stay at rest until the detect delay has run
            if (q.tick) begin
               d.on_cnt = q.on_cnt + 12'h001;
            end
            if (i_tone_present) begin
               d.gap_cnt = 12'h000;
               d.cand    = i_tone_code;
            end else if (q.tick) begin
               d.gap_cnt = q.gap_cnt + 12'h001;
            end
            if (q.gap_cnt > drop1_ticks) begin
               d.state = ST_IDLE;
            end else if (q.on_cnt >= delay_ticks) begin
               d.state   = ST_CODE;
               d.code    = q.cand;
               d.gap_cnt = 12'h000;
            end
         end
         ST_CODE: begin
            // Strobe follows the code after a short fixed delay
            if (q.tick) begin
               d.gap_cnt = q.gap_cnt + 12'h001;
            end
            if (q.gap_cnt >= spdly_ticks) begin
               d.state    = ST_VALID;
               d.strobe_n = 1'b0;
               d.gap_cnt  = 12'h000;
            end
         end
         ST_VALID: begin
            // A new digit without a long gap keeps the current output
            if (i_tone_present) begin
               d.gap_cnt = 12'h000;
            end else if (q.tick) begin
               d.gap_cnt = q.gap_cnt + 12'h001;
            end
            if (q.gap_cnt >= hold_ticks) begin
               d.state    = ST_IDLE;
               d.code     = `DTQ_CODE_IDLE;
               d.strobe_n = `DTQ_STROBE_IDLE;
               d.gap_cnt  = 12'h000;
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase
      if (i_power_down) begin
         d.state    = ST_IDLE;
         d.on_cnt   = 12'h000;
         d.gap_cnt  = 12'h000;
         d.code     = `DTQ_CODE_IDLE;
         d.strobe_n = `DTQ_STROBE_IDLE;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         q.state    <= ST_IDLE;
         q.tick_cnt <= 16'h0000;
         q.tick     <= 1'b0;
         q.on_cnt   <= 12'h000;
         q.gap_cnt  <= 12'h000;
         q.cand     <= `DTQ_CODE_IDLE;
         q.code     <= `DTQ_CODE_IDLE;
         q.strobe_n <= `DTQ_STROBE_IDLE;
      end else begin
         q <= d;
      end
   end

   assign o_received_digit_code  = q.code;
   assign o_digit_valid_strobe_n = q.strobe_n;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   chk_strobe_after_code: assert property (
      $fell(q.strobe_n) |-> $past(q.state) == ST_CODE
                            && $past(q.gap_cnt) >= spdly_ticks)
      else $error("strobe fell without code delay");

   chk_accept_time: assert property (
      (q.state == ST_CODE && $past(q.state) == ST_QUAL)
         |-> $past(q.on_cnt) >= $past(delay_ticks))
      else $error("digit accepted before detect delay");

   chk_reject_quiet: assert property (
      q.state == ST_QUAL |-> q.strobe_n && q.code == `DTQ_CODE_IDLE)
      else $error("outputs moved during qualification");

   chk_idle_clear: assert property (
      q.state == ST_IDLE |=> q.strobe_n && q.code == `DTQ_CODE_IDLE)
      else $error("outputs not cleared at rest");

   chk_drop_before: assert property (
      ($past(q.state) == ST_QUAL && q.state == ST_IDLE && !$past(i_power_down))
         |-> $past(q.gap_cnt) > $past(drop1_ticks))
      else $error("short gap aborted qualification");

   chk_drop_during: assert property (
      ($past(q.state) == ST_VALID && q.state != ST_VALID
       && !$past(i_power_down))
         |-> $past(q.gap_cnt) > $past(drop2_ticks))
      else $error("short gap released strobe");

   chk_change_keeps: assert property (
      (q.state == ST_VALID && $past(q.state) == ST_VALID)
         |-> $stable(q.code) && !q.strobe_n)
      else $error("output changed during valid digit");

   chk_tick_spacing: assert property (
      q.tick |=> !q.tick)
      else $error("time base ticks back to back");

   chk_power_down: assert property (
      i_power_down |=> q.state == ST_IDLE && q.strobe_n)
      else $error("power down did not clear");

   // Release must honour the hold count of the mode in force at the time
   chk_mode_hold: assert property (
      ($past(q.state) == ST_VALID && q.state == ST_IDLE
       && !$past(i_power_down))
         |-> $past(q.gap_cnt) >= ($past(i_fast_detect_select)
                                  ? to_ticks(`DTQ_HOLD_FAST_US)
                                  : to_ticks(`DTQ_HOLD_NORM_US)))
      else $error("hold time not met for selected mode");

   chk_strobe_with_code: assert property (
      !q.strobe_n |-> q.state == ST_VALID)
      else $error("strobe low outside valid digit");

endmodule : dtq_qualifier

`default_nettype wire

/* bench/dtq_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dtq_host_model (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // Receiver outputs
   input  wire logic [3:0] i_code,
   input  wire logic       i_strobe_n,
   // Captured digit
   output logic            o_cap_valid,
   output logic      [3:0] o_cap_code
);
   logic strobe_q;
   // Latch the code only on the falling edge of the strobe
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         strobe_q    <= 1'b1;
         o_cap_valid <= 1'b0;
         o_cap_code  <= 4'h0;
      end else begin
         strobe_q    <= i_strobe_n;
         o_cap_valid <= strobe_q & ~i_strobe_n;
         if (strobe_q & ~i_strobe_n) o_cap_code <= i_code;
      end
   end
endmodule : dtq_host_model

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int T = 10;
   logic       clk         = 1'b0;
   logic       rst         = 1'b1;
   logic       tone        = 1'b0;
   logic       fast        = 1'b0;
   logic       pd          = 1'b0;
   logic       strobe_n;
   logic       cap_v;
   logic [3:0] tcode       = 4'h0;
   logic [3:0] code;
   logic [3:0] cap_c;
   logic [3:0] exp_q[$];
   logic [7:0] lf          = 8'h4A;
   int         err_count   = 0;
   int         check_count = 0;
   int         n;

   always #5 clk = ~clk;

   dtq_qualifier #(.TICK_CYC(T)) dut (
      .i_sys_clk              (clk),
      .i_rst                  (rst),
      .i_tone_present         (tone),
      .i_tone_code            (tcode),
      .i_fast_detect_select   (fast),
      .i_power_down           (pd),
      .o_received_digit_code  (code),
      .o_digit_valid_strobe_n (strobe_n)
   );

   dtq_host_model host (
      .i_sys_clk   (clk),
      .i_rst       (rst),
      .i_code      (code),
      .i_strobe_n  (strobe_n),
      .o_cap_valid (cap_v),
      .o_cap_code  (cap_c)
   );

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic check(input string nm, input logic [3:0] s,
                        input logic [3:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   task automatic conclude;
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic drive(input logic t, input int ticks);
      @(posedge clk);
      tone <= t;
      repeat (ticks * T) @(posedge clk);
   endtask : drive

   // Whole digit with gaps before and during output and a code change
   task automatic digit(input int d, input int h);
      logic ok;
      lf = lfsr_next(lf);
      exp_q.push_back(lf[3:0]);
      @(posedge clk);
      tcode <= lf[3:0];
      drive(1'b1, 100);
      drive(1'b0, 3);
      drive(1'b1, 0);
      for (n = 104 * T; n < (d + 12) * T && strobe_n !== 1'b0; n++)
         @(negedge clk);
      check("strobe fall", {3'h0, strobe_n}, 4'h0);
      if (strobe_n !== 1'b0) begin
         conclude();
      end
      ok = (n >= (d + 6) * T) && (n <= (d + 10) * T);
      check("delay", {3'h0, ok}, 4'h1);
      repeat (20 * T) @(posedge clk);
      drive(1'b0, 25);
      drive(1'b1, 0);
      tcode <= ~lf[3:0];
      repeat (50 * T) @(negedge clk);
      check("code kept", code, lf[3:0]);
      check("strobe kept", {3'h0, strobe_n}, 4'h0);
      drive(1'b0, h - 2);
      @(negedge clk);
      check("held", {3'h0, strobe_n}, 4'h0);
      for (n = 0; n < 4 * T && strobe_n !== 1'b1; n++)
         @(negedge clk);
      check("released", {3'h0, strobe_n}, 4'h1);
      check("code clear", code, 4'h0);
      repeat (350 * T) @(posedge clk);
   endtask : digit

   // Short or broken bursts must leave both outputs untouched
   task automatic burst(input int on1, input int gap, input int on2);
      int lows;
      lows = 0;
      drive(1'b1, on1);
      if (gap > 0) begin
         drive(1'b0, gap);
         drive(1'b1, on2);
      end
      drive(1'b0, 0);
      repeat (450 * T) begin
         @(negedge clk);
         if (strobe_n !== 1'b1 || code !== 4'h0) lows++;
      end
      check("burst", {3'h0, lows != 0}, 4'h0);
   endtask : burst

   // Power down while a digit is shown clears both outputs at once
   task automatic pdown(input int d);
      lf = lfsr_next(lf);
      exp_q.push_back(lf[3:0]);
      @(posedge clk);
      tcode <= lf[3:0];
      drive(1'b1, 0);
      for (n = 0; n < (d + 12) * T && strobe_n !== 1'b0; n++)
         @(negedge clk);
      check("pd strobe fall", {3'h0, strobe_n}, 4'h0);
      if (strobe_n !== 1'b0) begin
         conclude();
      end
      @(posedge clk);
      tone <= 1'b0;
      pd   <= 1'b1;
      @(posedge clk);
      pd <= 1'b0;
      @(negedge clk);
      check("pd strobe", {3'h0, strobe_n}, 4'h1);
      check("pd code", code, 4'h0);
      repeat (350 * T) @(posedge clk);
   endtask : pdown

   always @(negedge clk) begin
      if (cap_v === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("extra capture", 4'h1, 4'h0);
         end else begin
            check("capture", cap_c, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 3; i++) digit(410, 280);
      burst(230, 0, 0);
      burst(200, 10, 200);
      @(posedge clk);
      fast <= 1'b1;
      for (int i = 0; i < 3; i++) digit(260, 200);
      burst(95, 0, 0);
      pdown(260);
      repeat (10) @(posedge clk);
      check("pending", 4'(exp_q.size()), 4'h0);
      conclude();
   end
endmodule : tb

`default_nettype wire
